/* rtl/sio_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Shared address bus plus the bit-serial data group
interface sio_bus_if;
	logic [14:0] addr;
	logic        memory_cycle_enable;
	logic        io_cycle;
	logic        serial_out_line;
	logic        serial_out_strobe;
	logic        serial_in_line;

	modport cpu
	(
		output addr,
		output memory_cycle_enable,
		output io_cycle,
		output serial_out_line,
		output serial_out_strobe,
		input  serial_in_line
	);
	modport periph
	(
		input  addr,
		input  memory_cycle_enable,
		input  io_cycle,
		input  serial_out_line,
		input  serial_out_strobe,
		output serial_in_line
	);
endinterface
`default_nettype wire

/* rtl/sio_cpu_end.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - One serial input and one output line
// - Strobe pulses mark each output bit
// - Address bus shared, told apart by controls
// - I/O drives bits 0-11, top three zero
// - Memory cycles drive bits 0-14 only
// - Base is base register bits 1-12
// - Single-bit address adds sign-extended displacement
// - Bit address placed at instruction start
// - Multi-bit ops start at base unchanged
// - Base equals register value halved, top dropped
// - Timing derived from the system clock
// - Serial interface at 0040 and 0050
// - Mask/timer at 0080, parallel at 0090
// - Address five cycles, two-cycle strobe, late sample
// - Multi-bit address increments per bit
// - Test bit copies input to equal flag
module sio_cpu_end
(
	input  wire logic                       sys_clk,
	input  wire logic                       reset,
	sio_bus_if.cpu                          bus,
	input  wire logic                       cmd_valid,
	output logic                            cmd_ready,
	input  wire sio_pkg::op_e               cmd_op,
	input  wire logic [15:0]                cmd_base_reg,
	input  wire logic [7:0]                 cmd_disp,
	input  wire logic [4:0]                 cmd_count,
	input  wire logic [15:0]                cmd_data,
	input  wire logic                       mem_req,
	input  wire logic [15:0]                mem_addr,
	output logic                            mem_byte_sel,
	output logic [15:0]                     rd_data,
	output logic                            rd_valid,
	input  wire logic                       rd_ready,
	output logic                            equal_flag,
	output logic                            busy
);
	typedef enum logic [1:0] {IDLE, XFER, PUSH} state_e;

	state_e            state_r;
	sio_pkg::op_e      op_r;
	logic [11:0]       addr_r;
	logic [4:0]        left_r;
	logic [3:0]        idx_r;
	logic [15:0]       data_r;
	logic [2:0]        phase_r;
	logic [14:0]       bus_addr_r;
	logic              io_r;
	logic              mem_r;
	logic              out_r;
	logic              strobe_r;
	logic              eq_r;
	logic              byte_r;
	logic              in_s1_r;
	logic              in_s2_r;
	logic              fifo_in_ready;
	logic              single;
	logic [11:0]       hw_base;
	logic [11:0]       disp_ext;
	logic [11:0]       first_addr;
	logic [4:0]        count_eff;
	logic              is_out;
	logic              strobe_on;
	logic              sample_now;
	logic              bit_done;

	// Base from register bits 1-12, i.e. value halved, top dropped
	assign hw_base    = cmd_base_reg[12:1];
	assign disp_ext   = {{4{cmd_disp[7]}}, cmd_disp};
	assign single     = cmd_op == sio_pkg::OP_SET_ONE ||
		cmd_op == sio_pkg::OP_SET_ZERO || cmd_op == sio_pkg::OP_TEST;
	assign first_addr = single ? hw_base + disp_ext : hw_base;
	// A count of zero means a full block of sixteen
	assign count_eff  = single ? 5'h01 :
		(cmd_count == 5'h00 || cmd_count > 5'h10) ? 5'h10 : cmd_count;
	assign is_out     = op_r != sio_pkg::OP_TEST && op_r != sio_pkg::OP_STORE;
	assign strobe_on  = is_out && (phase_r == 3'(sio_pkg::STROBE_START) ||
		phase_r == 3'(sio_pkg::STROBE_START + 1));
	// Sampling early would read the previous address through the lag
	assign sample_now = phase_r == 3'(sio_pkg::SAMPLE_PHASE);
	assign bit_done   = phase_r == 3'(sio_pkg::BIT_PHASES - 1);
	assign cmd_ready  = state_r == IDLE && !mem_req;
	assign busy       = state_r != IDLE;

	// Bus outputs: one address bus, cycle kind told by controls
	assign bus.addr                = bus_addr_r;
	assign bus.io_cycle            = io_r;
	assign bus.memory_cycle_enable = mem_r;
	assign bus.serial_out_line     = out_r;
	assign bus.serial_out_strobe   = strobe_r;
	assign mem_byte_sel            = byte_r;
	assign equal_flag              = eq_r;

	// Two-flop synchroniser on the serial input
	always_ff @(posedge sys_clk)
	begin
		in_s1_r <= bus.serial_in_line;
		in_s2_r <= in_s1_r;
	end

	// Sequencer: each bit takes eight phases, one clock cycle each
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			state_r    <= IDLE;
			op_r       <= sio_pkg::OP_TEST;
			addr_r     <= '0;
			left_r     <= '0;
			idx_r      <= '0;
			data_r     <= '0;
			phase_r    <= '0;
			bus_addr_r <= '0;
			io_r       <= 1'b0;
			mem_r      <= 1'b0;
			out_r      <= 1'b0;
			strobe_r   <= 1'b0;
			eq_r       <= 1'b0;
			byte_r     <= 1'b0;
		end
		else
		begin
			case (state_r)
				IDLE:
				begin
					strobe_r <= 1'b0;
					io_r     <= 1'b0;
					mem_r    <= mem_req;
					if (mem_req)
					begin
						bus_addr_r <= mem_addr[15:1];
						byte_r     <= mem_addr[0];
					end
					else if (cmd_valid)
					begin
						op_r       <= cmd_op;
						addr_r     <= first_addr;
						left_r     <= count_eff;
						idx_r      <= '0;
						data_r     <= cmd_op == sio_pkg::OP_STORE ? 16'h0000 :
							cmd_data;
						phase_r    <= '0;
						bus_addr_r <= {3'b000, first_addr};
						io_r       <= 1'b1;
						state_r    <= XFER;
					end
				end
				XFER:
				begin
					phase_r  <= phase_r + 3'h1;
					strobe_r <= strobe_on;
					case (op_r)
						sio_pkg::OP_SET_ONE:  out_r <= 1'b1;
						sio_pkg::OP_SET_ZERO: out_r <= 1'b0;
						sio_pkg::OP_LOAD:     out_r <= data_r[idx_r];
						default:              out_r <= out_r;
					endcase
					if (sample_now && op_r == sio_pkg::OP_TEST)
						eq_r <= in_s2_r;
					if (sample_now && op_r == sio_pkg::OP_STORE)
						data_r[idx_r] <= in_s2_r;
					if (bit_done)
					begin
						left_r     <= left_r - 5'h01;
						idx_r      <= idx_r + 4'h1;
						addr_r     <= addr_r + 12'h001;
						bus_addr_r <= {3'b000, addr_r + 12'h001};
						if (left_r == 5'h01)
						begin
							io_r    <= 1'b0;
							state_r <= op_r == sio_pkg::OP_STORE ? PUSH : IDLE;
						end
					end
				end
				PUSH:
				begin
					if (fifo_in_ready)
						state_r <= IDLE;
				end
				default:
					state_r <= IDLE;
			endcase
		end
	end

	// Stored words queue toward the user and stall on full
	sio_fifo #(.WIDTH(16), .DEPTH(sio_pkg::FIFO_DEPTH)) i_sio_fifo
	(
		.sys_clk   (sys_clk),
		.reset     (reset),
		.in_data   (data_r),
		.in_valid  (state_r == PUSH),
		.in_ready  (fifo_in_ready),
		.out_data  (rd_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready)
	);
endmodule
`default_nettype wire

/* rtl/sio_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module sio_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
)
(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	// Wrap-around pointers need a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin : g_bad_param
		$error("bad depth");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	wire              push;
	wire              pop;

	// Full and empty from the extra pointer bit
	assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid = wr_r != rd_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_r[AW-1:0]];

	// Pointer and storage update
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
		end
		if (push)
			mem[wr_r[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

/* rtl/sio_periph_end.sv */
`timescale 1ns/100ps
`default_nettype none
// Board decode and a bank of addressable bits per region
module sio_periph_end
(
	input  wire logic        sys_clk,
	input  wire logic        reset,
	sio_bus_if.periph        bus,
	input  wire logic [63:0] in_bits,
	output logic [63:0]      out_bits,
	output logic [3:0]       region_hit
);
	localparam logic [11:0] BASES [4] = '{sio_pkg::SERIAL_LO_BASE,
		sio_pkg::SERIAL_HI_BASE, sio_pkg::MASK_TIMER_BASE,
		sio_pkg::PARALLEL_BASE};

	logic [11:0] bit_addr;
	logic [1:0]  s1_r;
	logic [1:0]  s2_r;
	logic        strobe_d_r;
	logic        in_r;
	logic        io_c;
	logic        strobe_c;
	logic        dat_c;
	logic [63:0] out_r;
	logic [63:0] hit_bit;

	// Synchronise the control pair from the processor
	always_ff @(posedge sys_clk)
	begin
		s1_r <= {bus.serial_out_strobe, bus.io_cycle};
		s2_r <= s1_r;
	end

	// Decode only bits 0-11, qualified by an I/O cycle
	assign bit_addr = bus.addr[11:0];
	assign io_c     = s2_r[0] && !bus.memory_cycle_enable;
	assign strobe_c = s2_r[1];
	assign dat_c    = bus.serial_out_line;

	genvar g;
	generate
		for (g = 0; g < 64; g++)
		begin : g_bit
			assign hit_bit[g] = io_c &&
				bit_addr == BASES[g/16] + 12'(g % 16);
		end
		for (g = 0; g < 4; g++)
		begin : g_reg
			assign region_hit[g] = |hit_bit[g*16 +: 16];
		end
	endgenerate

	// Latch output bit on strobe rise; register the addressed input every cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			out_r      <= '0;
			strobe_d_r <= 1'b0;
			in_r       <= 1'b0;
		end
		else
		begin
			strobe_d_r <= strobe_c;
			if (strobe_c && !strobe_d_r)
				out_r <= (out_r & ~hit_bit) | (hit_bit & {64{dat_c}});
			in_r <= |(hit_bit & in_bits);
		end
	end

	assign out_bits           = out_r;
	assign bus.serial_in_line = in_r;
endmodule
`default_nettype wire

/* rtl/sio_pkg.sv */
package sio_pkg;
	// Operation codes of the bit-serial channel
	typedef enum logic [2:0]
	{
		OP_SET_ONE,
		OP_SET_ZERO,
		OP_TEST,
		OP_LOAD,
		OP_STORE
	} op_e;

	localparam int ADDR_W         = 15;
	localparam int BASE_LSB       = 3;
	localparam int BASE_MSB       = 14;
	localparam int BASE_W         = 12;
	localparam int DISP_W         = 8;
	localparam int COUNT_W        = 5;
	localparam int MAX_BITS       = 16;
	localparam int PHASES         = 4;
	localparam int BIT_PHASES     = 8;
	localparam int STROBE_START   = 4;
	localparam int STROBE_PHASES  = 2;
	// Late in the slot: the peripheral answer is registered, then synchronised
	localparam int SAMPLE_PHASE   = 6;
	localparam int STATUS_EQ_BIT  = 2;
	localparam int FIFO_DEPTH     = 32;
	localparam logic [BASE_W-1:0] SERIAL_LO_BASE  = 12'h040;
	localparam logic [BASE_W-1:0] SERIAL_HI_BASE  = 12'h050;
	localparam logic [BASE_W-1:0] MASK_TIMER_BASE = 12'h080;
	localparam logic [BASE_W-1:0] PARALLEL_BASE   = 12'h090;
	localparam int BLOCK_BITS     = 16;
endpackage

/* test/sio_bus_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the shared bus between the two ends
module sio_bus_chk
(
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic [14:0] addr,
	input wire logic        memory_cycle_enable,
	input wire logic        io_cycle,
	input wire logic        serial_out_line,
	input wire logic        serial_out_strobe,
	input wire logic        serial_in_line
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// Strobe shape: two high cycles, then low
	sequence s_pulse;
		serial_out_strobe [*2] ##1 !serial_out_strobe;
	endsequence
	// Bit address holds for six cycles after the I/O cycle rises
	sequence s_hold;
		$stable(addr) [*6];
	endsequence

	// Bus relations
	property p_top_zero;
		io_cycle |-> addr[14:12] == 3'h0;
	endproperty
	property p_excl;
		!(io_cycle && memory_cycle_enable);
	endproperty
	property p_strobe_io;
		serial_out_strobe |-> io_cycle;
	endproperty
	property p_pulse;
		$rose(serial_out_strobe) |-> s_pulse;
	endproperty
	property p_phase;
		$rose(serial_out_strobe) |-> $past(io_cycle, 4);
	endproperty
	property p_hold;
		$rose(io_cycle) |=> s_hold;
	endproperty
	property p_step;
		io_cycle && $past(io_cycle) && $changed(addr)
			|-> addr == $past(addr) + 15'h0001;
	endproperty
	property p_steady;
		serial_out_strobe && $past(serial_out_strobe)
			|-> $stable(serial_out_line);
	endproperty
	// No device answers once the I/O cycle has been gone a while
	property p_in_quiet;
		!io_cycle [*4] |-> !serial_in_line;
	endproperty

	a_top_zero: assert property (p_top_zero) else $error("io addr top");
	a_excl: assert property (p_excl) else $error("cycle overlap");
	a_strobe_io: assert property (p_strobe_io) else $error("stray strobe");
	a_pulse: assert property (p_pulse) else $error("strobe width");
	a_phase: assert property (p_phase) else $error("strobe phase");
	a_hold: assert property (p_hold) else $error("addr hold");
	a_step: assert property (p_step) else $error("addr step");
	a_steady: assert property (p_steady) else $error("data moved");
	a_in_quiet: assert property (p_in_quiet) else $error("input busy");
endmodule
`default_nettype wire

/* test/tb_bit_serial_io_addressing.sv */
`timescale 1ns/100ps
`default_nettype none
// Drives both ends through their user sides
module tb_bit_serial_io_addressing;
	logic         sys_clk = 1'b0;
	logic         reset = 1'b1;
	logic         cmd_valid = 1'b0;
	sio_pkg::op_e cmd_op = sio_pkg::OP_SET_ONE;
	logic [15:0]  cmd_base_reg = 16'h0000;
	logic [7:0]   cmd_disp = 8'h00;
	logic [4:0]   cmd_count = 5'h00;
	logic [15:0]  cmd_data = 16'h0000;
	logic         mem_req = 1'b0;
	logic [15:0]  mem_addr = 16'h0000;
	logic         rd_ready = 1'b0;
	logic [63:0]  in_bits = 64'h0;
	logic         cmd_ready;
	logic         mem_byte_sel;
	logic [15:0]  rd_data;
	logic         rd_valid;
	logic         equal_flag;
	logic         busy;
	logic [63:0]  out_bits;
	logic [3:0]   region_hit;
	logic [15:0]  expq[$];
	int           n_fail = 0;
	int           comparisons = 0;
	int           cycles = 0;

	sio_bus_if bus();
	sio_cpu_end i_sio_cpu_end(.sys_clk(sys_clk), .reset(reset), .bus(bus),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_base_reg(cmd_base_reg), .cmd_disp(cmd_disp),
		.cmd_count(cmd_count), .cmd_data(cmd_data), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_byte_sel(mem_byte_sel), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .equal_flag(equal_flag),
		.busy(busy));
	sio_periph_end i_sio_periph_end(.sys_clk(sys_clk), .reset(reset),
		.bus(bus), .in_bits(in_bits), .out_bits(out_bits),
		.region_hit(region_hit));
	sio_bus_chk i_sio_bus_chk(.sys_clk(sys_clk), .reset(reset),
		.addr(bus.addr), .memory_cycle_enable(bus.memory_cycle_enable),
		.io_cycle(bus.io_cycle), .serial_out_line(bus.serial_out_line),
		.serial_out_strobe(bus.serial_out_strobe),
		.serial_in_line(bus.serial_in_line));

	// Clock and hang guard
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			n_fail++;
		end
	endtask

	// Holds a command until taken, then drops it
	task automatic issue(input sio_pkg::op_e op, input logic [15:0] base,
		input logic [7:0] disp, input logic [4:0] cnt);
		@(negedge sys_clk);
		cmd_op = op;
		cmd_base_reg = base;
		cmd_disp = disp;
		cmd_count = cnt;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
	endtask

	task automatic idle_wait;
		@(negedge sys_clk);
		while (busy !== 1'b0)
			@(negedge sys_clk);
	endtask

	task automatic t_single;
		issue(sio_pkg::OP_SET_ONE, 16'h00A0, 8'hF3, 5'h00);
		repeat (2) @(negedge sys_clk);
		check(16'(region_hit), 16'h0001);
		idle_wait();
		check(16'(out_bits[3]), 16'h0001);
		issue(sio_pkg::OP_SET_ZERO, 16'h80A1, 8'hF3, 5'h00);
		idle_wait();
		check(16'(out_bits[3]), 16'h0000);
		$display("test single done");
	endtask

	task automatic t_test;
		in_bits[54:52] = 3'h2;
		issue(sio_pkg::OP_TEST, 16'h0120, 8'h05, 5'h00);
		repeat (2) @(negedge sys_clk);
		check(16'(region_hit), 16'h0008);
		idle_wait();
		check(16'(equal_flag), 16'h0001);
		// Neighbours set, addressed bit clear
		in_bits[54:52] = 3'h5;
		issue(sio_pkg::OP_TEST, 16'h0120, 8'h05, 5'h00);
		idle_wait();
		check(16'(equal_flag), 16'h0000);
		// Negative displacement reaches the same bit
		in_bits[54:52] = 3'h2;
		issue(sio_pkg::OP_TEST, 16'h0130, 8'hFD, 5'h00);
		idle_wait();
		check(16'(equal_flag), 16'h0001);
		in_bits[54:52] = 3'h0;
		$display("test bit done");
	endtask

	task automatic t_load;
		cmd_data = 16'hA5C3;
		issue(sio_pkg::OP_LOAD, 16'h0100, 8'h00, 5'h00);
		repeat (2) @(negedge sys_clk);
		check(16'(region_hit), 16'h0004);
		idle_wait();
		check(out_bits[47:32], 16'hA5C3);
		$display("test load done");
	endtask

	task automatic t_mem;
		@(negedge sys_clk);
		mem_req = 1'b1;
		mem_addr = 16'h0121;
		@(negedge sys_clk);
		check(16'(cmd_ready), 16'h0000);
		@(negedge sys_clk);
		check(16'(bus.addr), 16'h0090);
		check(16'(mem_byte_sel), 16'h0001);
		check(16'(bus.memory_cycle_enable), 16'h0001);
		check(16'(bus.io_cycle), 16'h0000);
		// Address aliases a device, but a memory cycle selects none
		repeat (2) @(negedge sys_clk);
		check(16'(region_hit), 16'h0000);
		mem_req = 1'b0;
		$display("test memory done");
	endtask

	// Fills the result buffer past full, then drains it
	task automatic t_fifo;
		in_bits[15:0] = 16'h3C69;
		in_bits[18:16] = 3'h5;
		issue(sio_pkg::OP_STORE, 16'h00A0, 8'h00, 5'h03);
		repeat (2) @(negedge sys_clk);
		check(16'(region_hit), 16'h0002);
		expq.push_back(16'h0005);
		for (int i = 0; i < 32; i++)
		begin
			if (i > 0)
				idle_wait();
			issue(sio_pkg::OP_STORE, 16'((12'h040 + i % 16) * 2), 8'h00, 5'h01);
			expq.push_back(16'(in_bits[i % 16]));
		end
		repeat (30) @(negedge sys_clk);
		check(16'(busy), 16'h0001);
		foreach (expq[j])
		begin
			while (rd_valid !== 1'b1)
				@(negedge sys_clk);
			check(rd_data, expq[j]);
			rd_ready = 1'b1;
			@(negedge sys_clk);
			rd_ready = 1'b0;
		end
		idle_wait();
		check(16'(rd_valid), 16'h0000);
		$display("test store done");
	endtask

	// Main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		t_single();
		t_test();
		t_load();
		t_mem();
		t_fifo();
		stop_test();
	end
endmodule
`default_nettype wire
